//--- common/asbbe_pkg.sv
// constants and types shared by the add, shift, bit and branch execution datapath
package asbbe_pkg;

	localparam int DATA_WIDTH            = 8;
	localparam int FILE_ADDR_WIDTH       = 7;
	localparam int FILE_DEPTH            = 128;
	localparam int BIT_SEL_WIDTH         = 3;
	localparam int BRANCH_LIT_WIDTH      = 9;
	localparam int PROGRAM_COUNTER_WIDTH = 15;
	localparam int NIBBLE_CARRY_POS      = 4;

	localparam logic [7:0]  ACC_RESET_VALUE             = 8'h00;
	localparam logic [7:0]  RESULT_RESET_VALUE          = 8'h00;
	localparam logic        FLAG_RESET_VALUE            = 1'h0;
	localparam logic [14:0] PROGRAM_COUNTER_RESET_VALUE = 15'h0000;
	localparam logic [14:0] PROGRAM_COUNTER_STEP        = 15'h0001;
	localparam logic        DEST_ACC                    = 1'h0;
	localparam logic        DEST_FILE                   = 1'h1;

	// command codes presented on the command port
	typedef enum logic [3:0] {
		OP_NO_OPERATION          = 4'h0,
		OP_ADD_ACC_TO_FILE       = 4'h1,
		OP_ADD_ACC_FILE_CARRY    = 4'h2,
		OP_ARITH_SHIFT_RIGHT     = 4'h3,
		OP_BIT_CLEAR_FILE        = 4'h4,
		OP_BIT_SET_FILE          = 4'h5,
		OP_RELATIVE_BRANCH_LIT   = 4'h6,
		OP_RELATIVE_BRANCH_ACC   = 4'h7,
		OP_LOAD_ACC_LITERAL      = 4'h8,
		OP_LOAD_FILE_LITERAL     = 4'h9
	} asbbe_op_t;

	typedef enum logic [2:0] {
		ST_IDLE         = 3'h1,
		ST_EXEC         = 3'h2,
		ST_NO_OPERATION = 3'h4
	} asbbe_state_t;

endpackage : asbbe_pkg

//--- verilog/asbbe_file_ram.sv
// file register memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module asbbe_file_ram #(
	parameter int DEPTH      = asbbe_pkg::FILE_DEPTH,
	parameter int ADDR_WIDTH = asbbe_pkg::FILE_ADDR_WIDTH,
	parameter int DATA_WIDTH = asbbe_pkg::DATA_WIDTH
) (
	// clocking
	input  wire logic                  clock,
	input  wire logic                  clkEn,
	// read side
	input  wire logic [ADDR_WIDTH-1:0] rdAddr,
	output logic      [DATA_WIDTH-1:0] rdData,
	// write side
	input  wire logic                  wrEn,
	input  wire logic [ADDR_WIDTH-1:0] wrAddr,
	input  wire logic [DATA_WIDTH-1:0] wrData
);

	logic [DATA_WIDTH-1:0] mem [DEPTH];

	// read during write to the same word returns the old contents
	always_ff @(posedge clock) begin
		if (clkEn) begin
			rdData <= mem[rdAddr];
			if (wrEn) begin
				mem[wrAddr] <= wrData;
			end
		end
	end

endmodule : asbbe_file_ram

`default_nettype wire

//--- verilog/asbbe_exec.sv
// execution datapath for add, shift, bit set/clear and relative branch operations
//
// Functional notes
// - add of accumulator and addressed file word (0..127) updates carry, digit carry and zero.
// - destination select 0 writes the accumulator, 1 writes the addressed file word; bit clear and bit set always write the file word.
// - shift right moves file bits 7:1 into result bits 6:0 and old bit 0 into carry, touching only carry and zero.
// - shift right copies source bit 7 into result bit 7 so the sign is kept.
// - add with carry sums accumulator, file word and carry, honours the select bit and updates all three flags.
// - bit clear forces bit b of the file word to zero, keeps other bits and leaves the flags alone.
// - bit set forces the selected bit of the file word to one, keeps other bits and leaves the flags alone.
// - literal branch loads counter plus one plus the sign-extended 9-bit offset and takes two cycles.
// - accumulator branch adds the unsigned accumulator to counter plus one and takes two cycles.
// - each of the two relative branch operations spends its second cycle as a no-operation.
`timescale 1ns/1ps
`default_nettype none

module asbbe_exec #(
	parameter int PCW = asbbe_pkg::PROGRAM_COUNTER_WIDTH
) (
	// clock and reset
	input  wire logic                                     clock,
	input  wire logic                                     rst_n,
	input  wire logic                                     clkEn,
	// command port
	input  wire logic                                     cmdValid,
	input  wire asbbe_pkg::asbbe_op_t                     cmdOp,
	input  wire logic [asbbe_pkg::FILE_ADDR_WIDTH-1:0]    cmdAddr,
	input  wire logic                                     cmdDest,
	input  wire logic [asbbe_pkg::BIT_SEL_WIDTH-1:0]      cmdBit,
	input  wire logic [asbbe_pkg::BRANCH_LIT_WIDTH-1:0]   cmdLit,
	output logic                                          cmdReady,
	output logic                                          execNop,
	// architectural state
	output logic      [asbbe_pkg::DATA_WIDTH-1:0]         accReg,
	output logic      [asbbe_pkg::DATA_WIDTH-1:0]         resultReg,
	output logic                                          carryFlag,
	output logic                                          digitCarryFlag,
	output logic                                          zeroFlag,
	output logic      [PCW-1:0]                           programCounter
);

	typedef struct packed {
		asbbe_pkg::asbbe_state_t state;
		asbbe_pkg::asbbe_op_t    op;
		logic [6:0]              addr;
		logic                    dest;
		logic [2:0]              bitSel;
		logic [7:0]              acc;
		logic [7:0]              result;
		logic                    carry;
		logic                    digitCarry;
		logic                    zero;
		logic [PCW-1:0]          pc;
	} asbbe_ctx_t;

	asbbe_ctx_t ctx_reg;
	asbbe_ctx_t ctx_next;

	logic [7:0]     fileData;
	logic           ramWrEn;
	logic [6:0]     ramWrAddr;
	logic [7:0]     ramWrData;
	logic           addCarryIn;
	logic [8:0]     addSum;
	logic [4:0]     nibbleSum;
	logic [7:0]     execValue;
	logic [PCW-1:0] branchLitExt;
	logic [PCW-1:0] branchAccExt;
	logic [PCW-1:0] pcStep;

	// one-hot mask for a bit position, shared by bit set and clear
	function automatic logic [7:0] asbbe_bit_mask(input logic [2:0] pos);
		asbbe_bit_mask = 8'h01 << pos;
	endfunction : asbbe_bit_mask

	asbbe_file_ram #(
		.DEPTH      (asbbe_pkg::FILE_DEPTH),
		.ADDR_WIDTH (asbbe_pkg::FILE_ADDR_WIDTH),
		.DATA_WIDTH (asbbe_pkg::DATA_WIDTH)
	) u_file_ram (
		.clock  (clock),
		.clkEn  (clkEn),
		.rdAddr (cmdAddr),
		.rdData (fileData),
		.wrEn   (ramWrEn),
		.wrAddr (ramWrAddr),
		.wrData (ramWrData)
	);

	assign pcStep       = PCW'(asbbe_pkg::PROGRAM_COUNTER_STEP);
	assign branchLitExt = {{(PCW-asbbe_pkg::BRANCH_LIT_WIDTH){cmdLit[8]}}, cmdLit};
	assign branchAccExt = {{(PCW-asbbe_pkg::DATA_WIDTH){1'b0}}, ctx_reg.acc};

	// adder shared by both add operations; carry enters only for add with carry
	assign addCarryIn = (ctx_reg.op == asbbe_pkg::OP_ADD_ACC_FILE_CARRY) ? ctx_reg.carry : 1'b0;
	assign addSum     = {1'b0, ctx_reg.acc} + {1'b0, fileData} + {8'h00, addCarryIn};
	assign nibbleSum  = {1'b0, ctx_reg.acc[3:0]} + {1'b0, fileData[3:0]} + {4'h0, addCarryIn};

	always_comb begin
		ctx_next  = ctx_reg;
		ramWrEn   = 1'b0;
		ramWrAddr = ctx_reg.addr;
		ramWrData = 8'h00;
		execValue = 8'h00;
		case (ctx_reg.state)
			asbbe_pkg::ST_IDLE: begin
				if (cmdValid) begin
					ctx_next.op     = cmdOp;
					ctx_next.addr   = cmdAddr;
					ctx_next.dest   = cmdDest;
					ctx_next.bitSel = cmdBit;
					case (cmdOp)
						asbbe_pkg::OP_RELATIVE_BRANCH_LIT: begin
							ctx_next.pc    = PCW'(ctx_reg.pc + pcStep + branchLitExt);
							ctx_next.state = asbbe_pkg::ST_NO_OPERATION;
						end
						asbbe_pkg::OP_RELATIVE_BRANCH_ACC: begin
							ctx_next.pc    = PCW'(ctx_reg.pc + pcStep + branchAccExt);
							ctx_next.state = asbbe_pkg::ST_NO_OPERATION;
						end
						asbbe_pkg::OP_LOAD_ACC_LITERAL: begin
							ctx_next.acc = cmdLit[7:0];
							ctx_next.pc  = PCW'(ctx_reg.pc + pcStep);
						end
						asbbe_pkg::OP_LOAD_FILE_LITERAL: begin
							ramWrEn     = 1'b1;
							ramWrAddr   = cmdAddr;
							ramWrData   = cmdLit[7:0];
							ctx_next.pc = PCW'(ctx_reg.pc + pcStep);
						end
						asbbe_pkg::OP_NO_OPERATION: begin
							ctx_next.pc = PCW'(ctx_reg.pc + pcStep);
						end
						default: begin
							// file word is read at this edge and used in the next cycle
							ctx_next.state = asbbe_pkg::ST_EXEC;
						end
					endcase
				end
			end
			asbbe_pkg::ST_EXEC: begin
				case (ctx_reg.op)
					asbbe_pkg::OP_ADD_ACC_TO_FILE,
					asbbe_pkg::OP_ADD_ACC_FILE_CARRY: begin
						execValue           = addSum[7:0];
						ctx_next.carry      = addSum[8];
						ctx_next.digitCarry = nibbleSum[asbbe_pkg::NIBBLE_CARRY_POS];
						ctx_next.zero       = (addSum[7:0] == 8'h00);
					end
					asbbe_pkg::OP_ARITH_SHIFT_RIGHT: begin
						execValue      = {fileData[7], fileData[7:1]};
						ctx_next.carry = fileData[0];
						ctx_next.zero  = ({fileData[7], fileData[7:1]} == 8'h00);
					end
					asbbe_pkg::OP_BIT_CLEAR_FILE: begin
						execValue = fileData & ~asbbe_bit_mask(ctx_reg.bitSel);
					end
					asbbe_pkg::OP_BIT_SET_FILE: begin
						execValue = fileData | asbbe_bit_mask(ctx_reg.bitSel);
					end
					default: begin
						execValue = fileData;
					end
				endcase
				ctx_next.result = execValue;
				// bit operations always go back to the file word
				if ((ctx_reg.dest == asbbe_pkg::DEST_ACC) &&
				    (ctx_reg.op != asbbe_pkg::OP_BIT_CLEAR_FILE) &&
				    (ctx_reg.op != asbbe_pkg::OP_BIT_SET_FILE)) begin
					ctx_next.acc = execValue;
				end else begin
					ramWrEn   = 1'b1;
					ramWrData = execValue;
				end
				ctx_next.pc    = PCW'(ctx_reg.pc + pcStep);
				ctx_next.state = asbbe_pkg::ST_IDLE;
			end
			asbbe_pkg::ST_NO_OPERATION: begin
				ctx_next.state = asbbe_pkg::ST_IDLE;
			end
			default: begin
				ctx_next.state = asbbe_pkg::ST_IDLE;
			end
		endcase
		if (!clkEn) begin
			ramWrEn = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctx_reg.state      <= asbbe_pkg::ST_IDLE;
			ctx_reg.op         <= asbbe_pkg::OP_NO_OPERATION;
			ctx_reg.addr       <= 7'h00;
			ctx_reg.dest       <= asbbe_pkg::DEST_ACC;
			ctx_reg.bitSel     <= 3'h0;
			ctx_reg.acc        <= asbbe_pkg::ACC_RESET_VALUE;
			ctx_reg.result     <= asbbe_pkg::RESULT_RESET_VALUE;
			ctx_reg.carry      <= asbbe_pkg::FLAG_RESET_VALUE;
			ctx_reg.digitCarry <= asbbe_pkg::FLAG_RESET_VALUE;
			ctx_reg.zero       <= asbbe_pkg::FLAG_RESET_VALUE;
			ctx_reg.pc         <= PCW'(asbbe_pkg::PROGRAM_COUNTER_RESET_VALUE);
		end else if (clkEn) begin
			ctx_reg <= ctx_next;
		end
	end

	assign cmdReady       = (ctx_reg.state == asbbe_pkg::ST_IDLE);
	assign execNop        = (ctx_reg.state == asbbe_pkg::ST_NO_OPERATION);
	assign accReg         = ctx_reg.acc;
	assign resultReg      = ctx_reg.result;
	assign carryFlag      = ctx_reg.carry;
	assign digitCarryFlag = ctx_reg.digitCarry;
	assign zeroFlag       = ctx_reg.zero;
	assign programCounter = ctx_reg.pc;

	// helpers for the checks below
	logic execStep;
	logic idleTake;
	assign execStep = clkEn && (ctx_reg.state == asbbe_pkg::ST_EXEC);
	assign idleTake = clkEn && cmdValid && (ctx_reg.state == asbbe_pkg::ST_IDLE);

	a_add_sum_value: assert property (@(posedge clock) disable iff (!rst_n)
		execStep && (ctx_reg.op == asbbe_pkg::OP_ADD_ACC_TO_FILE)
		|=> resultReg == 8'($past(ctx_reg.acc) + $past(fileData)))
		else $error("add result does not equal accumulator plus file word");

	a_dest_to_acc: assert property (@(posedge clock) disable iff (!rst_n)
		execStep && (ctx_reg.dest == asbbe_pkg::DEST_ACC) && (ctx_reg.op == asbbe_pkg::OP_ARITH_SHIFT_RIGHT)
		|=> (accReg == resultReg))
		else $error("select 0 did not write the accumulator");

	a_shift_carry_out: assert property (@(posedge clock) disable iff (!rst_n)
		execStep && (ctx_reg.op == asbbe_pkg::OP_ARITH_SHIFT_RIGHT)
		|=> (carryFlag == $past(fileData[0])) && (resultReg[6:0] == $past(fileData[7:1])) && $stable(digitCarryFlag))
		else $error("shift right moved the wrong bits");

	a_shift_sign_kept: assert property (@(posedge clock) disable iff (!rst_n)
		execStep && (ctx_reg.op == asbbe_pkg::OP_ARITH_SHIFT_RIGHT)
		|=> resultReg[7] == $past(fileData[7]))
		else $error("shift right lost the sign bit");

	a_carry_in_add: assert property (@(posedge clock) disable iff (!rst_n)
		execStep && (ctx_reg.op == asbbe_pkg::OP_ADD_ACC_FILE_CARRY)
		|=> {carryFlag, resultReg} == 9'({1'b0, $past(ctx_reg.acc)} + {1'b0, $past(fileData)} + {8'h00, $past(ctx_reg.carry)}))
		else $error("add with carry gave a wrong sum");

	a_bit_clear_mask: assert property (@(posedge clock) disable iff (!rst_n)
		execStep && (ctx_reg.op == asbbe_pkg::OP_BIT_CLEAR_FILE)
		|=> (resultReg == ($past(fileData) & ~(8'h01 << $past(ctx_reg.bitSel)))) && $stable(zeroFlag) && $stable(carryFlag))
		else $error("bit clear changed the wrong bits or a flag");

	a_bit_set_mask: assert property (@(posedge clock) disable iff (!rst_n)
		execStep && (ctx_reg.op == asbbe_pkg::OP_BIT_SET_FILE)
		|=> (resultReg == ($past(fileData) | (8'h01 << $past(ctx_reg.bitSel)))) && $stable(digitCarryFlag))
		else $error("bit set changed the wrong bits or a flag");

	a_branch_lit_target: assert property (@(posedge clock) disable iff (!rst_n)
		idleTake && (cmdOp == asbbe_pkg::OP_RELATIVE_BRANCH_LIT)
		|=> programCounter == PCW'($past(ctx_reg.pc) + pcStep + $past(branchLitExt)))
		else $error("literal branch target is wrong");

	a_branch_acc_target: assert property (@(posedge clock) disable iff (!rst_n)
		idleTake && (cmdOp == asbbe_pkg::OP_RELATIVE_BRANCH_ACC)
		|=> programCounter == PCW'($past(ctx_reg.pc) + pcStep + $past(branchAccExt)))
		else $error("accumulator branch target is wrong");

	a_branch_second_nop: assert property (@(posedge clock) disable iff (!rst_n)
		idleTake && ((cmdOp == asbbe_pkg::OP_RELATIVE_BRANCH_LIT) || (cmdOp == asbbe_pkg::OP_RELATIVE_BRANCH_ACC))
		|=> execNop && !cmdReady ##1 ($stable(programCounter) && (cmdReady || execNop)))
		else $error("branch did not spend one no-operation cycle");

	a_zero_flag_add: assert property (@(posedge clock) disable iff (!rst_n)
		execStep && (ctx_reg.op == asbbe_pkg::OP_ADD_ACC_TO_FILE)
		|=> (zeroFlag == (resultReg == 8'h00)) &&
		    (digitCarryFlag == (({1'b0, $past(ctx_reg.acc[3:0])} + {1'b0, $past(fileData[3:0])}) > 5'h0f)))
		else $error("zero or digit carry flag wrong after add");

	a_branch_flags_kept: assert property (@(posedge clock) disable iff (!rst_n)
		idleTake && ((cmdOp == asbbe_pkg::OP_RELATIVE_BRANCH_LIT) || (cmdOp == asbbe_pkg::OP_RELATIVE_BRANCH_ACC))
		|=> $stable(carryFlag) && $stable(digitCarryFlag) && $stable(zeroFlag))
		else $error("branch changed a status flag");

endmodule : asbbe_exec

`default_nettype wire

//--- tb/asbbe_exec_tb.sv
// self-checking testbench for the add, shift, bit and branch execution datapath
`timescale 1ns/1ps
`default_nettype none

module asbbe_exec_tb;
	logic                 clock;
	logic                 rst_n;
	logic                 clkEn;
	logic                 cmdValid;
	asbbe_pkg::asbbe_op_t cmdOp;
	logic [6:0]           cmdAddr;
	logic                 cmdDest;
	logic [2:0]           cmdBit;
	logic [8:0]           cmdLit;
	logic                 cmdReady;
	logic                 execNop;
	logic [7:0]           accReg;
	logic [7:0]           resultReg;
	logic                 carryFlag;
	logic                 digitCarryFlag;
	logic                 zeroFlag;
	logic [14:0]          programCounter;
	int                   err_total;
	int                   checks;
	// reference state
	logic [7:0]           mFile [128];
	logic [7:0]           mAcc;
	logic [7:0]           mRes;
	logic [14:0]          mPc;
	logic                 mC;
	logic                 mDc;
	logic                 mZ;

	asbbe_exec u_asbbe_exec (
		.clock          (clock),
		.rst_n          (rst_n),
		.clkEn          (clkEn),
		.cmdValid       (cmdValid),
		.cmdOp          (cmdOp),
		.cmdAddr        (cmdAddr),
		.cmdDest        (cmdDest),
		.cmdBit         (cmdBit),
		.cmdLit         (cmdLit),
		.cmdReady       (cmdReady),
		.execNop        (execNop),
		.accReg         (accReg),
		.resultReg      (resultReg),
		.carryFlag      (carryFlag),
		.digitCarryFlag (digitCarryFlag),
		.zeroFlag       (zeroFlag),
		.programCounter (programCounter)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic finish_test();
		if (err_total == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic chk_state();
		chk({8'h00, accReg}, {8'h00, mAcc}, "accumulator");
		chk({1'b0, programCounter}, {1'b0, mPc}, "program counter");
		chk({13'h0, carryFlag, digitCarryFlag, zeroFlag}, {13'h0, mC, mDc, mZ}, "flags");
	endtask : chk_state

	// op codes: 1/2 add, 3 shift, 4/5 bit clear/set, 6/7 branches, 8/9 loads
	task automatic run(input logic [3:0] op, input logic [6:0] a, input logic d, input logic [2:0] b,
			input logic [8:0] k);
		int         n;
		logic       busy;
		logic       no_operation;
		logic       cin;
		logic [8:0] sum;
		logic [7:0] f;
		// one idle edge between commands keeps the strobe from being driven twice in a step
		@(posedge clock);
		#1;
		chk({15'h0, cmdReady}, 16'h1, "ready before command");
		cmdOp    = asbbe_pkg::asbbe_op_t'(op);
		cmdAddr  = a;
		cmdDest  = d;
		cmdBit   = b;
		cmdLit   = k;
		cmdValid = 1'b1;
		@(posedge clock);
		#1;
		cmdValid = 1'b0;
		busy = ~cmdReady;
		no_operation = execNop;
		n = 0;
		while (cmdReady !== 1'b1) begin
			@(posedge clock);
			#1;
			n++;
			if (n > 8) begin
				chk(16'h0, 16'h1, "ready timeout");
				finish_test();
			end
		end
		f = mFile[a];
		mPc = mPc + 15'h0001;
		case (op)
			4'h1, 4'h2: begin
				cin = (op == 4'h2) ? mC : 1'b0;
				sum = {1'b0, mAcc} + {1'b0, f} + {8'h00, cin};
				mDc = ({1'b0, mAcc[3:0]} + {1'b0, f[3:0]} + {4'h0, cin}) > 5'h0f;
				mC = sum[8];
				mRes = sum[7:0];
			end
			4'h3: begin
				mRes = {f[7], f[7:1]};
				mC = f[0];
			end
			4'h4: mRes = f & ~(8'h01 << b);
			4'h5: mRes = f | (8'h01 << b);
			4'h6: mPc = mPc + {{6{k[8]}}, k};
			4'h7: mPc = mPc + {7'h00, mAcc};
			4'h8: mAcc = k[7:0];
			4'h9: mFile[a] = k[7:0];
			default: ;
		endcase
		if (op >= 4'h1 && op <= 4'h5) begin
			if (op <= 4'h3) begin
				mZ = (mRes == 8'h00);
			end
			if (d == asbbe_pkg::DEST_ACC && op <= 4'h3) begin
				mAcc = mRes;
			end else begin
				mFile[a] = mRes;
			end
			chk({8'h00, resultReg}, {8'h00, mRes}, "result");
		end
		chk({15'h0, busy}, {15'h0, (op >= 4'h1 && op <= 4'h7)}, "busy cycle");
		chk({15'h0, no_operation}, {15'h0, (op == 4'h6 || op == 4'h7)}, "no-operation cycle");
		chk(n[15:0], {15'h0, (op >= 4'h1 && op <= 4'h7)}, "busy cycle count");
		chk_state();
	endtask : run

	task automatic t_reset();
		chk({15'h0, cmdReady}, 16'h1, "ready in reset");
		chk({15'h0, execNop}, 16'h0, "no-operation in reset");
		chk({8'h00, resultReg}, 16'h0, "result in reset");
		chk_state();
	endtask : t_reset

	task automatic t_add();
		run(4'h9, 7'h05, 1'b0, 3'h0, 9'h08f);
		run(4'h8, 7'h00, 1'b0, 3'h0, 9'h071);
		run(4'h1, 7'h05, 1'b0, 3'h0, 9'h000);
		run(4'h2, 7'h05, 1'b1, 3'h0, 9'h000);
		run(4'h1, 7'h05, 1'b0, 3'h0, 9'h000);
		run(4'h9, 7'h7f, 1'b0, 3'h0, 9'h0ff);
		run(4'h2, 7'h7f, 1'b0, 3'h0, 9'h000);
		run(4'h2, 7'h7f, 1'b0, 3'h0, 9'h000);
		run(4'h1, 7'h7f, 1'b1, 3'h0, 9'h000);
	endtask : t_add

	task automatic t_shift();
		run(4'h9, 7'h7f, 1'b0, 3'h0, 9'h081);
		run(4'h3, 7'h7f, 1'b0, 3'h0, 9'h000);
		run(4'h3, 7'h7f, 1'b1, 3'h0, 9'h000);
		run(4'h9, 7'h03, 1'b0, 3'h0, 9'h001);
		run(4'h3, 7'h03, 1'b0, 3'h0, 9'h000);
		run(4'h1, 7'h7f, 1'b0, 3'h0, 9'h000);
	endtask : t_shift

	task automatic t_bits();
		run(4'h9, 7'h00, 1'b0, 3'h0, 9'h000);
		for (int i = 0; i < 8; i++) begin
			run(4'h5, 7'h00, i[0], i[2:0], 9'h000);
		end
		for (int i = 7; i >= 0; i--) begin
			run(4'h4, 7'h00, i[1], i[2:0], 9'h000);
		end
		run(4'h1, 7'h00, 1'b0, 3'h0, 9'h000);
	endtask : t_bits

	task automatic t_branch();
		run(4'h8, 7'h00, 1'b0, 3'h0, 9'h0ff);
		run(4'h7, 7'h00, 1'b0, 3'h0, 9'h000);
		run(4'h6, 7'h00, 1'b0, 3'h0, 9'h0ff);
		run(4'h6, 7'h00, 1'b0, 3'h0, 9'h1ff);
		run(4'h6, 7'h00, 1'b0, 3'h0, 9'h100);
		run(4'h6, 7'h00, 1'b0, 3'h0, 9'h100);
		run(4'h6, 7'h00, 1'b0, 3'h0, 9'h100);
		run(4'h8, 7'h00, 1'b0, 3'h0, 9'h000);
		run(4'h7, 7'h00, 1'b0, 3'h0, 9'h000);
		run(4'h0, 7'h00, 1'b0, 3'h0, 9'h000);
	endtask : t_branch

	task automatic t_freeze();
		@(posedge clock);
		#1;
		clkEn = 1'b0;
		cmdOp = asbbe_pkg::OP_LOAD_ACC_LITERAL;
		cmdLit = 9'h05a;
		cmdValid = 1'b1;
		repeat (3) @(posedge clock);
		#1;
		cmdValid = 1'b0;
		clkEn = 1'b1;
		chk_state();
		run(4'h8, 7'h00, 1'b0, 3'h0, 9'h05a);
	endtask : t_freeze

	initial begin
		err_total = 0;
		checks = 0;
		rst_n = 1'b0;
		clkEn = 1'b1;
		cmdValid = 1'b0;
		cmdOp = asbbe_pkg::OP_NO_OPERATION;
		cmdAddr = 7'h00;
		cmdDest = 1'b0;
		cmdBit = 3'h0;
		cmdLit = 9'h000;
		mAcc = 8'h00;
		mRes = 8'h00;
		mPc = 15'h0000;
		mC = 1'b0;
		mDc = 1'b0;
		mZ = 1'b0;
		repeat (3) @(posedge clock);
		#1;
		t_reset();
		rst_n = 1'b1;
		t_add();
		t_shift();
		t_bits();
		t_branch();
		t_freeze();
		finish_test();
	end
endmodule : asbbe_exec_tb

`default_nettype wire
